// ### design/tdr_top.sv
// Two-wire debug port: frame decode, target select and data registers
`timescale 1ns/10ps
`default_nettype none
module tdr_top #(
    parameter logic [7:0] PART_ID = 8'hA5, // Arbitrary identity value
    parameter logic [7:0] REV_ID  = 8'h00  // Arbitrary revision value
) (
    input  wire logic       core_clk,          // Core clock, 50 MHz
    input  wire logic       rst_b,             // Async system reset, active low
    input  wire logic       debug_link_clock,  // Link clock from host
    input  wire logic       debug_link_data_i, // Data line level
    output logic            debug_link_data_o, // Data line drive value
    output logic            debug_link_data_oe,// Data line drive enable
    output logic [7:0]      link_target_select,// Current target select
    output logic            flash_prog_enable, // Programming unlocked
    output logic            fp_wr_stb,         // Data register written
    output logic [7:0]      fp_wr_data,        // Byte written to data register
    output logic            fp_rd_stb,         // Data register read
    input  wire logic [7:0] fp_rd_data         // Byte from flash engine
);
    // ============================================================
    // Pin synchronisation
    tdr_pkg::tdr_state_t st;
    tdr_pkg::tdr_state_t next_st;
    logic [1:0] pins_s;
    logic       clk_s;
    logic       data_s;
    logic       rise;

    tdr_sync u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({debug_link_clock, debug_link_data_i}),
        .sync_out (pins_s)
    );

    assign clk_s  = pins_s[1];
    assign data_s = pins_s[0];
    assign rise   = clk_s & ~st.clk_prev;

    // ============================================================
    // State
    logic [7:0]          rd_val;
    logic [7:0]          wr_val;
    logic [1:0]          ins_now;

    assign ins_now = {data_s, st.ins_lo};
    assign wr_val  = {data_s, st.shreg[7:1]};

    // Read mux; unmapped selects read as zero
    always_comb begin
        rd_val = tdr_pkg::BYTE_ZERO;
        if (ins_now == tdr_pkg::INS_ADDR_RD) begin
            rd_val = st.sel;
        end else begin
            case (st.sel)
                tdr_pkg::SEL_PART_ID: rd_val = PART_ID;
                tdr_pkg::SEL_REV_ID:  rd_val = REV_ID;
                tdr_pkg::SEL_FP_CTL:  rd_val = st.ctl_reg;
                tdr_pkg::SEL_FP_DAT:  rd_val = fp_rd_data;
                default:              rd_val = tdr_pkg::BYTE_ZERO;
            endcase
        end
    end

    // ============================================================
    // Frame engine, all register access by link only
    always_comb begin
        next_st          = st;
        next_st.clk_prev = clk_s;
        next_st.wr_stb   = 1'b0;
        next_st.rd_stb   = 1'b0;
        if (rise) begin
            case (st.state)
                tdr_pkg::ST_IDLE: begin
                    // Start bit is a low data level
                    if (!data_s) begin
                        next_st.state = tdr_pkg::ST_INS0;
                    end
                end
                tdr_pkg::ST_INS0: begin
                    next_st.ins_lo = data_s;
                    next_st.state  = tdr_pkg::ST_INS1;
                end
                tdr_pkg::ST_INS1: begin
                    next_st.ins_wr   = st.ins_lo;
                    next_st.ins_addr = data_s;
                    next_st.cnt      = tdr_pkg::CNT_ZERO;
                    if (st.ins_lo) begin
                        next_st.state = tdr_pkg::ST_WDATA;
                    end else begin
                        // Device takes the line only for read bits
                        next_st.shreg = rd_val;
                        next_st.dout  = rd_val[0];
                        next_st.doe   = 1'b1;
                        next_st.state = tdr_pkg::ST_RDATA;
                        next_st.rd_stb = !data_s && (st.sel == tdr_pkg::SEL_FP_DAT);
                    end
                end
                tdr_pkg::ST_WDATA: begin
                    next_st.shreg = wr_val;
                    next_st.cnt   = 3'(st.cnt + tdr_pkg::CNT_STEP);
                    if (st.cnt == tdr_pkg::BIT_LAST) begin
                        next_st.state = tdr_pkg::ST_IDLE;
                        if (st.ins_addr) begin
                            next_st.sel = wr_val;
                        end else if (st.sel == tdr_pkg::SEL_FP_CTL) begin
                            next_st.ctl_reg = wr_val;
                            // Any other byte breaks the unlock pair
                            next_st.unlock_step = (wr_val == tdr_pkg::UNLOCK_FIRST);
                            if (st.unlock_step && wr_val == tdr_pkg::UNLOCK_SECOND) begin
                                next_st.unlocked = 1'b1;
                            end
                        end else if (st.sel == tdr_pkg::SEL_FP_DAT) begin
                            next_st.wr_stb  = 1'b1;
                            next_st.wr_data = wr_val;
                        end
                    end
                end
                tdr_pkg::ST_RDATA: begin
                    if (st.cnt == tdr_pkg::BIT_LAST) begin
                        next_st.doe   = 1'b0;
                        next_st.dout  = 1'b0;
                        next_st.state = tdr_pkg::ST_IDLE;
                    end else begin
                        next_st.shreg = {1'b0, st.shreg[7:1]};
                        next_st.dout  = st.shreg[1];
                        next_st.cnt   = 3'(st.cnt + tdr_pkg::CNT_STEP);
                    end
                end
                default: begin
                    next_st.state = tdr_pkg::ST_IDLE;
                    next_st.doe   = 1'b0;
                end
            endcase
        end
    end

    // Only a system reset relocks programming
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st       <= '0;
            st.sel   <= tdr_pkg::SEL_RESET;
            st.state <= tdr_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign debug_link_data_o  = st.dout;
    assign debug_link_data_oe = st.doe;
    assign link_target_select = st.sel;
    assign flash_prog_enable  = st.unlocked;
    assign fp_wr_stb          = st.wr_stb;
    assign fp_wr_data         = st.wr_data;
    assign fp_rd_stb          = st.rd_stb;

    // ============================================================
    // Assertions
    sequence s_dread_start;
        rise && st.state == tdr_pkg::ST_INS1 && ins_now == tdr_pkg::INS_DATA_RD;
    endsequence

    sequence s_write_done;
        rise && st.state == tdr_pkg::ST_WDATA && st.cnt == tdr_pkg::BIT_LAST;
    endsequence

    property p_oe_read_only;
        @(posedge core_clk) disable iff (!rst_b)
        debug_link_data_oe |-> st.state == tdr_pkg::ST_RDATA;
    endproperty
    a_oe_read_only: assert property (p_oe_read_only) else $error("drive outside read");

    property p_sel_write;
        @(posedge core_clk) disable iff (!rst_b)
        s_write_done ##0 st.ins_addr |=> link_target_select == $past(wr_val);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select not written");

    property p_part_read;
        @(posedge core_clk) disable iff (!rst_b)
        s_dread_start ##0 (st.sel == tdr_pkg::SEL_PART_ID)
            |=> debug_link_data_oe && debug_link_data_o == PART_ID[0] && st.shreg == PART_ID;
    endproperty
    a_part_read: assert property (p_part_read) else $error("bad identity read");

    property p_rev_read;
        @(posedge core_clk) disable iff (!rst_b)
        s_dread_start ##0 (st.sel == tdr_pkg::SEL_REV_ID) |=> st.shreg == REV_ID;
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("bad revision read");

    property p_ctl_read;
        @(posedge core_clk) disable iff (!rst_b)
        s_dread_start ##0 (st.sel == tdr_pkg::SEL_FP_CTL) |=> st.shreg == $past(st.ctl_reg);
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("bad control read");

    property p_dat_write;
        @(posedge core_clk) disable iff (!rst_b)
        s_write_done ##0 (!st.ins_addr && st.sel == tdr_pkg::SEL_FP_DAT)
            |=> fp_wr_stb && fp_wr_data == $past(wr_val) ##1 !fp_wr_stb;
    endproperty
    a_dat_write: assert property (p_dat_write) else $error("data write lost");

    property p_unlock_sticky;
        @(posedge core_clk) disable iff (!rst_b)
        flash_prog_enable |=> flash_prog_enable;
    endproperty
    a_unlock_sticky: assert property (p_unlock_sticky) else $error("unlock dropped");

    property p_unlock_cause;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(flash_prog_enable) |-> st.ctl_reg == tdr_pkg::UNLOCK_SECOND && $past(st.unlock_step);
    endproperty
    a_unlock_cause: assert property (p_unlock_cause) else $error("unlock without pair");

    property p_id_readonly;
        @(posedge core_clk) disable iff (!rst_b)
        s_write_done ##0 (!st.ins_addr && st.sel != tdr_pkg::SEL_FP_CTL)
            |=> $stable(st.ctl_reg) && $stable(link_target_select);
    endproperty
    a_id_readonly: assert property (p_id_readonly) else $error("read-only target changed");
endmodule // tdr_top
`default_nettype wire

// ### design/tdr_pkg.sv
// Constants, state types and encodings for the two-wire debug register select block
// ============================================================
// How it works
// - The host drives the link clock and one shared data line carries bits both ways.
// - Every register of this port is reached only through link frames, never a processor bus.
// - An 8-bit target select register written over the link picks the target of data commands.
// - Select value 0x00 makes a data read return the part identity register.
// - Select value 0x01 makes a data read return the silicon revision register.
// - Select value 0x02 makes data reads and writes reach the flash programming control register.
// - Select value 0xB4 makes data reads and writes reach the flash programming data register.
// - Writing 0x02 then 0x01 to the control register unlocks programming until a system reset.
// - The part identity register is read-only and returns a fixed 8-bit code.
// - The flash data register carries flash commands, addresses and data to the flash engine.
// - The silicon revision register is read-only and returns an 8-bit revision code.
package tdr_pkg;

    // ============================================================
    // Target select values
    localparam logic [7:0] SEL_PART_ID  = 8'h00;
    localparam logic [7:0] SEL_REV_ID   = 8'h01;
    localparam logic [7:0] SEL_FP_CTL   = 8'h02;
    localparam logic [7:0] SEL_FP_DAT   = 8'hB4;
    localparam logic [7:0] SEL_RESET    = 8'h00;

    // ============================================================
    // Unlock codes and flash commands
    localparam logic [7:0] UNLOCK_FIRST  = 8'h02;
    localparam logic [7:0] UNLOCK_SECOND = 8'h01;
    localparam logic [7:0] FCMD_BLK_RD   = 8'h06;
    localparam logic [7:0] FCMD_BLK_WR   = 8'h07;
    localparam logic [7:0] FCMD_PG_ERASE = 8'h08;
    localparam logic [7:0] FCMD_DEV_ERASE = 8'h03;

    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic [2:0] CNT_ZERO      = 3'h0;
    localparam logic [2:0] CNT_STEP      = 3'h1;

    // ============================================================
    // Frame instruction codes, first bit in the low position
    typedef enum logic [1:0] {
        INS_DATA_RD = 2'h0,
        INS_DATA_WR = 2'h1,
        INS_ADDR_RD = 2'h2,
        INS_ADDR_WR = 2'h3
    } tdr_ins_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_INS0  = 3'h1,
        ST_INS1  = 3'h3,
        ST_WDATA = 3'h2,
        ST_RDATA = 3'h7
    } tdr_fsm_t;

    typedef struct packed {
        tdr_fsm_t   state;
        logic [2:0] cnt;
        logic       ins_lo;
        logic       ins_wr;
        logic       ins_addr;
        logic [7:0] shreg;
        logic [7:0] sel;
        logic [7:0] ctl_reg;
        logic       unlock_step;
        logic       unlocked;
        logic       clk_prev;
        logic       dout;
        logic       doe;
        logic       wr_stb;
        logic [7:0] wr_data;
        logic       rd_stb;
    } tdr_state_t;

    typedef struct packed {
        logic [1:0] stage1;
        logic [1:0] stage2;
    } tdr_sync_state_t;

endpackage

// ### design/tdr_sync.sv
// Two-flop synchroniser for the link clock and data pins
`timescale 1ns/10ps
`default_nettype none
module tdr_sync (
    input  wire logic       core_clk,   // Core clock
    input  wire logic       rst_b,      // Async reset, active low
    input  wire logic [1:0] async_in,   // Pin levels
    output logic      [1:0] sync_out    // Synchronised levels
);
    tdr_pkg::tdr_sync_state_t st;
    tdr_pkg::tdr_sync_state_t next_st;

    // First stage feeds only the second
    always_comb begin
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;
endmodule // tdr_sync
`default_nettype wire

// ### verification/tdr_host_model.sv
// Host adapter model that drives link frames into the debug port
`timescale 1ns/10ps
`default_nettype none
module tdr_host_model (
    input  wire logic core_clk,  // Core clock, paces the link
    input  wire logic dev_o,     // Device drive value
    input  wire logic dev_oe,    // Device drive enable
    output logic      link_clk,  // Link clock to device
    output logic      link_wire  // Resolved data line level
);
    logic host_d;
    logic host_oe;
    logic float_lvl;
    initial begin
        link_clk = 1'b0;
        host_d = 1'b1;
        host_oe = 1'b1;
        float_lvl = 1'b0;
    end
    // Undriven line shows the inverse of the last driven bit, so a stale bit never reads as valid
    always @(posedge core_clk) begin
        if (dev_oe || host_oe) begin
            float_lvl <= ~link_wire;
        end
    end
    assign link_wire = dev_oe ? dev_o : (host_oe ? host_d : float_lvl);
    // ============================================================
    // Link timing: 160 ns period, clock still low between frames
    task automatic half();
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic edge_bit(input logic b);
        host_d = b;
        half();
        link_clk = 1'b1;
        half();
        link_clk = 1'b0;
    endtask
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        host_oe = 1'b1;
        edge_bit(1'b0);
        edge_bit(ins[0]);
        if (!ins[0]) begin
            host_d = ins[1];
            half();
            link_clk = 1'b1;
            // Hold the last instruction bit until the device's first sync stage has taken it
            @(posedge core_clk);
            #1;
            host_oe = 1'b0;
            repeat (3) @(posedge core_clk);
            #1;
            link_clk = 1'b0;
            for (i = 0; i < 8; i++) begin
                half();
                link_clk = 1'b1;
                rd[i] = link_wire;
                half();
                link_clk = 1'b0;
            end
        end else begin
            edge_bit(ins[1]);
            for (i = 0; i < 8; i++) edge_bit(wd[i]);
        end
        host_oe = 1'b1;
        host_d = 1'b1;
        repeat (3) half();
    endtask
endmodule // tdr_host_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the debug port target select block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [7:0] PID = 8'h3C; // Arbitrary identity code
    localparam logic [7:0] RID = 8'h5A; // Arbitrary revision code
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] fp_rd_data = 8'h00;
    wire        link_clk;
    wire        link_wire;
    wire        dout;
    wire        doe;
    wire  [7:0] sel;
    wire        fpe;
    wire        wr_stb;
    wire  [7:0] wr_data;
    wire        rd_stb;
    int         err_count = 0;
    int         n_compared = 0;
    int         cycles = 0;
    int         wr_cnt = 0;
    int         rd_cnt = 0;

    tdr_top #(.PART_ID(PID), .REV_ID(RID)) tdr_top_inst (
        .core_clk(core_clk), .rst_b(rst_b), .debug_link_clock(link_clk),
        .debug_link_data_i(link_wire), .debug_link_data_o(dout),
        .debug_link_data_oe(doe), .link_target_select(sel), .flash_prog_enable(fpe),
        .fp_wr_stb(wr_stb), .fp_wr_data(wr_data), .fp_rd_stb(rd_stb),
        .fp_rd_data(fp_rd_data));
    tdr_host_model tdr_host_model_inst (
        .core_clk(core_clk), .dev_o(dout), .dev_oe(doe),
        .link_clk(link_clk), .link_wire(link_wire));

    always #10 core_clk = ~core_clk;
    // ============================================================
    // Strobe counters and hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (wr_stb === 1'b1) wr_cnt++;
        if (rd_stb === 1'b1) rd_cnt++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic aw(input logic [7:0] v);
        logic [7:0] r;
        tdr_host_model_inst.frame(2'h3, v, r);
    endtask
    task automatic dw(input logic [7:0] v);
        logic [7:0] r;
        tdr_host_model_inst.frame(2'h1, v, r);
    endtask
    task automatic drd(input logic [7:0] exp);
        logic [7:0] r;
        tdr_host_model_inst.frame(2'h0, 8'h00, r);
        check(r, exp);
    endtask
    task automatic ard(input logic [7:0] exp);
        logic [7:0] r;
        tdr_host_model_inst.frame(2'h2, 8'h00, r);
        check(r, exp);
    endtask
    // ============================================================
    // Scenarios
    task automatic t_reset();
        check(sel, 8'h00);
        check({5'h00, fpe, wr_stb, doe}, 8'h00);
        drd(PID);
        ard(8'h00);
    endtask
    task automatic t_ids();
        int n;
        aw(8'h01);
        check(sel, 8'h01);
        drd(RID);
        n = wr_cnt;
        dw(8'hFF);
        drd(RID);
        aw(8'h00);
        dw(8'hFF);
        drd(PID);
        check(8'(wr_cnt - n), 8'h00);
    endtask
    task automatic t_unlock();
        aw(8'h02);
        drd(8'h00);
        dw(8'h02);
        dw(8'h05);
        dw(8'h01);
        check({7'h00, fpe}, 8'h00);
        drd(8'h01);
        dw(8'h02);
        dw(8'h01);
        check({7'h00, fpe}, 8'h01);
        dw(8'h00);
        check({7'h00, fpe}, 8'h01);
        do_reset();
        check({7'h00, fpe}, 8'h00);
        check(sel, 8'h00);
    endtask
    task automatic t_flash_prog_data_reg();
        logic [7:0] cmds [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
        int n;
        aw(8'hB4);
        check(sel, 8'hB4);
        foreach (cmds[k]) begin
            n = wr_cnt;
            dw(cmds[k]);
            check(8'(wr_cnt - n), 8'h01);
            check(wr_data, cmds[k]);
        end
        fp_rd_data = 8'hC3;
        n = rd_cnt;
        drd(8'hC3);
        check(8'(rd_cnt - n), 8'h01);
    endtask
    task automatic t_unmapped();
        int n;
        aw(8'h55);
        n = wr_cnt;
        dw(8'hAA);
        check(8'(wr_cnt - n), 8'h00);
        drd(8'h00);
        ard(8'h55);
    endtask

    initial begin
        do_reset();
        t_reset();
        t_ids();
        t_unlock();
        t_flash_prog_data_reg();
        t_unmapped();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
